// *** hdl/flash_host_cfg.svh ***
// constants for the flash command host: command codes, unlock table, read offsets, timing
// assumes a 50 MHz clk and a flash whose bus cycles the host times itself
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define CMD_RESET 8'hF0
`define CMD_QUERY 8'h98
`define CMD_IDENT 8'h90
// unlock table, x16 word addresses and x8 byte addresses
`define UNLOCK1_ADDR16 12'h555
`define UNLOCK2_ADDR16 12'h2AA
`define UNLOCK1_ADDR8 12'hAAA
`define UNLOCK2_ADDR8 12'h555
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_DATA 8'h55
`define QUERY_ADDR16 12'h055
`define QUERY_ADDR8 12'h0AA
// read offsets within identification space (low address bits)
`define OFS_MAKER 7'h00
`define OFS_DEV1 7'h01
`define OFS_DEV2 7'h0E
`define OFS_DEV3 7'h0F
`define OFS_PROT 7'h02
`define OFS_XBLK 7'h03
`define PROT_SET 8'h01
`define XBLK_LOCKED 8'h80
`define ERROR_BIT 5
`define BUSY_BIT 6
// timing
`define CLK_NS 20
`define CYCLE_NS 80
`define CYCLE_CLKS ((`CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define ABORT_US 10
`define ABORT_CLKS ((`ABORT_US * 1000 + `CLK_NS - 1) / `CLK_NS)

`endif

// *** hdl/flash_host_pkg.sv ***
// types for the flash command host
// assumes flash_host_cfg.svh for numbers
package flash_host_pkg;
  typedef enum logic [2:0] {
    OP_RESET1, OP_RESET3, OP_IDENT, OP_QUERY, OP_READ, OP_WRITE
  } op_e;
  typedef enum logic [1:0] {
    MODE_ARRAY, MODE_IDENT, MODE_QUERY, MODE_SUSPEND
  } mode_e;
endpackage

// *** hdl/bus_cycle.sv ***
// one asynchronous flash bus cycle: write strobe or read with sampling
// assumes pins are timed purely by clk counts; dq input is synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module bus_cycle #(
  parameter int AW = 22,
  parameter int DW = 16,
  parameter int HOLD = `CYCLE_CLKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic done,
  output logic [DW-1:0] rdata,
  // pins
  output logic [AW-1:0] pin_addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [DW-1:0] dq_in
);
  localparam int CW = $clog2(HOLD + 4);
  logic [CW-1:0] cnt_r;
  logic busy_r;
  logic [DW-1:0] s1_r, s2_r, s3_r;
  // three stages: the third is taken whether or not it matches the second
  wire logic [DW-1:0] stable = (s2_r == s3_r) ? s2_r : s3_r;
  wire logic last = busy_r && (cnt_r == CW'(HOLD + 2));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= dq_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      done <= 1'b0;
      rdata <= '0;
      pin_addr <= '0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_out <= '0;
      dq_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r <= '0;
        pin_addr <= addr;
        ce_n <= 1'b0;
        oe_n <= write;
        we_n <= !write;
        dq_out <= wdata;
        dq_oe_n <= !write;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 1'b1;
        // write strobe ends HOLD clocks in; ce_n, and oe_n on a read, stay low for the 3 extra clocks that cover the input sync
        if (cnt_r == CW'(HOLD - 1)) begin
          we_n <= 1'b1;
        end
        if (last) begin
          busy_r <= 1'b0;
          done <= 1'b1;
          rdata <= stable;
          ce_n <= 1'b1;
          oe_n <= 1'b1;
          dq_oe_n <= 1'b1;
        end
      end
    end
  end
endmodule // bus_cycle
`default_nettype wire

// *** hdl/flash_cmd_host.sv ***
// host controller issuing command sequences to a parallel flash and tracking its read mode
// assumes one request at a time on the user port; flash pins timed by bus_cycle
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_cmd_host #(
  parameter int AW = 22,
  parameter int DW = 16,
  parameter int ABORT_CLKS = `ABORT_CLKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user request
  input wire logic req,
  input wire flash_host_pkg::op_e op,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_data,
  input wire logic bus_x16,
  input wire logic erase_timeout,
  input wire logic suspended,
  output logic ack,
  output logic refused,
  output logic [DW-1:0] rsp_data,
  output logic rsp_valid_data,
  output flash_host_pkg::mode_e mode,
  output logic error_seen,
  output logic cmd_busy,
  // flash pins
  output logic [AW-1:0] pin_addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [DW-1:0] dq_in,
  input wire logic ready_busy_n,
  output logic id_high_voltage_level
);
  typedef enum {S_IDLE, S_CYC, S_WAIT, S_ABORT} st_e;
  st_e st_r;
  flash_host_pkg::op_e op_r;
  flash_host_pkg::mode_e prev_r;
  logic [1:0] step_r, nsteps_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] data_r;
  localparam int ABW = $clog2(ABORT_CLKS + 1);
  logic [ABW-1:0] abort_r;
  logic cyc_start_r, cyc_write_r, cyc_done;
  logic [AW-1:0] cyc_addr_r;
  logic [DW-1:0] cyc_wdata_r, cyc_rdata;
  logic [2:0] rb_r;

  // unlock addresses per bus width
  function automatic logic [AW-1:0] ul_addr(input logic x16, input logic second);
    logic [11:0] a;
    a = x16 ? (second ? `UNLOCK2_ADDR16 : `UNLOCK1_ADDR16)
            : (second ? `UNLOCK2_ADDR8 : `UNLOCK1_ADDR8);
    return AW'(a);
  endfunction

  wire logic busy_pin = (rb_r[1] == rb_r[2]) ? !rb_r[2] : 1'b0;
  wire logic in_ident = (mode == flash_host_pkg::MODE_IDENT);
  // legality of a command against the tracked mode, error flag and busy pin
  wire logic is_reset = (op == flash_host_pkg::OP_RESET1) || (op == flash_host_pkg::OP_RESET3);
  wire logic bad_err = error_seen && !is_reset && (op != flash_host_pkg::OP_READ);
  wire logic bad_ident = (op == flash_host_pkg::OP_IDENT) && busy_pin && !suspended;
  wire logic bad_query = (op == flash_host_pkg::OP_QUERY) &&
    (mode != flash_host_pkg::MODE_ARRAY) && !in_ident;
  wire logic bad_in_id = in_ident && (op == flash_host_pkg::OP_WRITE);
  wire logic refuse = bad_err || bad_ident || bad_query || bad_in_id;
  wire logic [1:0] steps = (op == flash_host_pkg::OP_RESET3 || op == flash_host_pkg::OP_IDENT)
    ? 2'd3 : 2'd1;
  wire logic [AW-1:0] query_a = AW'(bus_x16 ? `QUERY_ADDR16 : `QUERY_ADDR8);
  wire logic [DW-1:0] cmd_code = (op_r == flash_host_pkg::OP_IDENT) ? DW'(`CMD_IDENT)
    : (op_r == flash_host_pkg::OP_QUERY) ? DW'(`CMD_QUERY)
    : (op_r == flash_host_pkg::OP_WRITE) ? data_r : DW'(`CMD_RESET);
  wire logic final_step = (step_r == nsteps_r - 2'd1);
  wire logic [AW-1:0] step_addr = (op_r == flash_host_pkg::OP_READ) ? addr_r
    : (op_r == flash_host_pkg::OP_WRITE) ? addr_r
    : (op_r == flash_host_pkg::OP_QUERY) ? query_a
    : final_step ? ul_addr(bus_x16, 1'b0) : ul_addr(bus_x16, step_r[0]);
  wire logic [DW-1:0] step_data = final_step ? cmd_code
    : (step_r[0] ? DW'(`UNLOCK2_DATA) : DW'(`UNLOCK1_DATA));

  function automatic logic is_reset_r();
    return (op_r == flash_host_pkg::OP_RESET1) || (op_r == flash_host_pkg::OP_RESET3);
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rb_r <= 3'b111;
    end else begin
      rb_r <= {rb_r[1:0], ready_busy_n};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= S_IDLE;
      op_r <= flash_host_pkg::OP_READ;
      prev_r <= flash_host_pkg::MODE_ARRAY;
      mode <= flash_host_pkg::MODE_ARRAY;
      step_r <= '0;
      nsteps_r <= 2'd1;
      addr_r <= '0;
      data_r <= '0;
      abort_r <= '0;
      cyc_start_r <= 1'b0;
      cyc_write_r <= 1'b0;
      cyc_addr_r <= '0;
      cyc_wdata_r <= '0;
      ack <= 1'b0;
      refused <= 1'b0;
      rsp_data <= '0;
      rsp_valid_data <= 1'b0;
      error_seen <= 1'b0;
      cmd_busy <= 1'b0;
      id_high_voltage_level <= 1'b0;
    end else begin
      ack <= 1'b0;
      refused <= 1'b0;
      cyc_start_r <= 1'b0;
      unique case (st_r)
        S_IDLE: begin
          if (req && refuse) begin
            refused <= 1'b1;
          end else if (req) begin
            op_r <= op;
            addr_r <= req_addr;
            data_r <= req_data;
            step_r <= '0;
            nsteps_r <= steps;
            cmd_busy <= 1'b1;
            st_r <= S_CYC;
          end
        end
        S_CYC: begin
          cyc_start_r <= 1'b1;
          cyc_write_r <= (op_r != flash_host_pkg::OP_READ);
          cyc_addr_r <= step_addr;
          cyc_wdata_r <= step_data;
          st_r <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done && !final_step) begin
            step_r <= step_r + 2'd1;
            st_r <= S_CYC;
          end else if (cyc_done) begin
            rsp_data <= cyc_rdata;
            // status word while busy, else data belongs to current mode
            rsp_valid_data <= (op_r == flash_host_pkg::OP_READ) && !busy_pin;
            if (op_r == flash_host_pkg::OP_READ && busy_pin && cyc_rdata[`ERROR_BIT]) begin
              error_seen <= 1'b1;
            end
            unique case (op_r)
              flash_host_pkg::OP_RESET1, flash_host_pkg::OP_RESET3: begin
                error_seen <= 1'b0;
                if (mode == flash_host_pkg::MODE_QUERY) begin
                  mode <= prev_r;
                end else if (in_ident && suspended) begin
                  mode <= flash_host_pkg::MODE_SUSPEND;
                end else if (mode == flash_host_pkg::MODE_SUSPEND) begin
                  mode <= flash_host_pkg::MODE_SUSPEND;
                end else begin
                  mode <= flash_host_pkg::MODE_ARRAY;
                end
              end
              flash_host_pkg::OP_IDENT: mode <= flash_host_pkg::MODE_IDENT;
              flash_host_pkg::OP_QUERY: begin
                prev_r <= mode;
                mode <= flash_host_pkg::MODE_QUERY;
              end
              default: begin
              end
            endcase
            if (is_reset_r() && erase_timeout) begin
              abort_r <= '0;
              st_r <= S_ABORT;
            end else begin
              ack <= 1'b1;
              cmd_busy <= 1'b0;
              st_r <= S_IDLE;
            end
          end
        end
        S_ABORT: begin
          abort_r <= abort_r + 1'b1;
          if (abort_r == ABW'(ABORT_CLKS - 1)) begin
            ack <= 1'b1;
            cmd_busy <= 1'b0;
            st_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  bus_cycle #(.AW(AW), .DW(DW)) u_cyc (
    .clk(clk),
    .rst(rst),
    .start(cyc_start_r),
    .write(cyc_write_r),
    .addr(cyc_addr_r),
    .wdata(cyc_wdata_r),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pin_addr(pin_addr),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .dq_in(dq_in)
  );
endmodule // flash_cmd_host
`default_nettype wire

// *** dv/flash_cmd_host_monitor.sv ***
// pin and handshake assertions for the flash command host
// assumes it is bound to flash_cmd_host
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // handshake
  input wire flash_host_pkg::op_e op,
  input wire logic ack,
  input wire logic refused,
  input wire flash_host_pkg::mode_e mode,
  // pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic dq_oe_n,
  input wire logic id_high_voltage_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  answer_excl_a: assert property (!(ack && refused))
    else $error("ack and refused together");
  refuse_pulse_a: assert property (refused |=> !refused)
    else $error("refused longer than one cycle");
  write_select_a: assert property (!we_n |-> !ce_n)
    else $error("write strobe without chip select");
  write_drive_a: assert property (!we_n |-> !dq_oe_n)
    else $error("write strobe with data bus released");
  read_release_a: assert property (!oe_n |-> dq_oe_n && we_n)
    else $error("data driven during read");
  write_hold_a: assert property ($fell(we_n) |=> !we_n [*2])
    else $error("write strobe too short");
  query_mode_a: assert property (ack && op == flash_host_pkg::OP_QUERY
    |-> ##[0:1] mode == flash_host_pkg::MODE_QUERY)
    else $error("query accepted without query mode");
  hv_idle_a: assert property (!id_high_voltage_level)
    else $error("high voltage level raised");
endmodule // flash_cmd_host_monitor
bind flash_cmd_host flash_cmd_host_monitor u_mon (.clk(clk), .rst(rst), .op(op), .ack(ack),
  .refused(refused), .mode(mode), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_oe_n(dq_oe_n),
  .id_high_voltage_level(id_high_voltage_level));
`default_nettype wire

// *** dv/flash_model.sv ***
// behavioural flash: command decoder, read modes, status word
// assumes x16 word data; busy, error and lock state set by the bench
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_model #(
  parameter logic [15:0] SIG_BASE = 16'h5A00 // arbitrary signature base
) (
  // pins
  input wire logic [21:0] pin_addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in,
  output logic ready_busy_n,
  // bench controls
  input wire logic x16,
  input wire logic busy,
  input wire logic err,
  input wire logic prot,
  input wire logic xlock
);
  logic [1:0] md, prev, seq;
  logic [15:0] rd, last;
  logic tgl;
  wire [11:0] a = pin_addr[11:0];
  wire [11:0] u1 = x16 ? `UNLOCK1_ADDR16 : `UNLOCK1_ADDR8;
  wire [11:0] u2 = x16 ? `UNLOCK2_ADDR16 : `UNLOCK2_ADDR8;
  wire [11:0] qa = x16 ? `QUERY_ADDR16 : `QUERY_ADDR8;
  wire [7:0] d = dq_out[7:0];
  assign ready_busy_n = !busy;
  initial begin md = 0; prev = 0; seq = 0; last = 0; tgl = 0; end
  always @(posedge we_n) if (!ce_n) begin
    if (d == `CMD_RESET) begin md <= (md == 2) ? prev : 2'd0; seq <= 0; end
    else if (seq == 0 && a == u1 && d == `UNLOCK1_DATA) seq <= 1;
    else if (seq == 1 && a == u2 && d == `UNLOCK2_DATA) seq <= 2;
    else if (seq == 2 && a == u1 && d == `CMD_IDENT) begin seq <= 0; if (!busy) md <= 1; end
    else if (d == `CMD_QUERY && a == qa && md != 2) begin prev <= md; md <= 2; seq <= 0; end
    else begin seq <= 0; if (md != 1) md <= 0; end
  end
  // released bus shows the inverse, never the stale value
  always @(negedge oe_n) tgl <= !tgl;
  always @(posedge oe_n) last <= rd;
  always_comb begin
    if (busy) rd = {9'h0, tgl, err, 5'h0};
    else if (md == 2) rd = 16'hC000 | a;
    else if (md == 1) case (a[3:0])
      4'h2: rd = {15'h0, prot};
      4'h3: rd = {8'h0, xlock, 7'h0};
      default: rd = SIG_BASE | a[3:0];
    endcase
    else rd = ~pin_addr[15:0];
  end
  assign dq_in = (!ce_n && !oe_n) ? rd : ~last;
endmodule // flash_model
`default_nettype wire

// *** dv/flash_cmd_host_tb.sv ***
// self-checking bench for the flash command host against the flash model
// assumes 50 MHz clk and abort wait shortened to 60 cycles
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module flash_cmd_host_tb;
  logic clk = 0, rst = 1, req = 0, bus_x16 = 1, erase_timeout = 0, suspended = 0;
  logic busy = 0, err = 0, prot = 0, xlock = 0, rf;
  flash_host_pkg::op_e op = flash_host_pkg::OP_READ;
  logic [21:0] req_addr = 0, pin_addr;
  logic [15:0] req_data = 0, rsp_data, dq_out, dq_in;
  logic ack, refused, rsp_valid_data, error_seen, cmd_busy, ce_n, oe_n, we_n, dq_oe_n;
  logic ready_busy_n, id_high_voltage_level;
  flash_host_pkg::mode_e mode;
  int fails = 0, comparisons = 0, lat;
  logic [3:0] ofs [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
  always #10 clk = ~clk;
  flash_cmd_host #(.ABORT_CLKS(60)) u_flash_cmd_host (.clk(clk), .rst(rst), .req(req), .op(op),
    .req_addr(req_addr), .req_data(req_data), .bus_x16(bus_x16), .erase_timeout(erase_timeout),
    .suspended(suspended), .ack(ack), .refused(refused), .rsp_data(rsp_data),
    .rsp_valid_data(rsp_valid_data), .mode(mode), .error_seen(error_seen), .cmd_busy(cmd_busy),
    .pin_addr(pin_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dq_in(dq_in), .ready_busy_n(ready_busy_n),
    .id_high_voltage_level(id_high_voltage_level));
  flash_model u_flash_model (.pin_addr(pin_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .dq_out(dq_out), .dq_in(dq_in), .ready_busy_n(ready_busy_n), .x16(bus_x16), .busy(busy),
    .err(err), .prot(prot), .xlock(xlock));
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input flash_host_pkg::op_e o, input logic [21:0] ad);
    int n;
    @(negedge clk); req = 1; op = o; req_addr = ad;
    @(negedge clk); req = 0;
    n = 0;
    while (!ack && !refused && n < 3000) begin @(negedge clk); n++; end
    lat = n; rf = refused;
    if (n >= 3000) begin
      fails++;
      summarize();
    end
  endtask
  task automatic t_ident();
    run(flash_host_pkg::OP_IDENT, 0); `CHK(rf, 1'b0)
    `CHK(mode, flash_host_pkg::MODE_IDENT)
    foreach (ofs[i]) begin run(flash_host_pkg::OP_READ, {18'h3, ofs[i]}); `CHK(rsp_data, 16'h5A00 | ofs[i]) end
    prot = 1; xlock = 1;
    run(flash_host_pkg::OP_READ, 22'h2); `CHK(rsp_data, 16'h0001)
    run(flash_host_pkg::OP_READ, 22'h3); `CHK(rsp_data, 16'h0080)
    `CHK(rsp_valid_data, 1'b1)
    run(flash_host_pkg::OP_WRITE, 22'h40); `CHK(rf, 1'b1)
    $display("ident test done");
  endtask
  task automatic t_query();
    run(flash_host_pkg::OP_QUERY, 0); `CHK(mode, flash_host_pkg::MODE_QUERY)
    run(flash_host_pkg::OP_READ, 22'h10); `CHK(rsp_data, 16'hC010)
    run(flash_host_pkg::OP_QUERY, 0); `CHK(rf, 1'b1)
    run(flash_host_pkg::OP_RESET1, 0); `CHK(mode, flash_host_pkg::MODE_IDENT)
    run(flash_host_pkg::OP_RESET3, 0); `CHK(mode, flash_host_pkg::MODE_ARRAY)
    run(flash_host_pkg::OP_READ, 22'h1234); `CHK(rsp_data, 16'hEDCB)
    $display("query test done");
  endtask
  task automatic t_x8();
    bus_x16 = 0;
    run(flash_host_pkg::OP_IDENT, 0); `CHK(mode, flash_host_pkg::MODE_IDENT)
    run(flash_host_pkg::OP_READ, 22'h0); `CHK(rsp_data, 16'h5A00)
    run(flash_host_pkg::OP_RESET1, 0); `CHK(mode, flash_host_pkg::MODE_ARRAY)
    bus_x16 = 1;
    $display("x8 test done");
  endtask
  task automatic t_busy();
    busy = 1;
    // busy crosses a three-flop synchroniser before the host sees it
    repeat (3) @(negedge clk);
    run(flash_host_pkg::OP_IDENT, 0); `CHK(rf, 1'b1)
    run(flash_host_pkg::OP_READ, 22'h5); `CHK(rsp_valid_data, 1'b0)
    err = 1;
    run(flash_host_pkg::OP_READ, 22'h5); `CHK(error_seen, 1'b1)
    run(flash_host_pkg::OP_WRITE, 22'h5); `CHK(rf, 1'b1)
    busy = 0; err = 0;
    run(flash_host_pkg::OP_RESET1, 0); `CHK(rf, 1'b0)
    `CHK(error_seen, 1'b0)
    $display("busy test done");
  endtask
  task automatic t_abort();
    erase_timeout = 1;
    run(flash_host_pkg::OP_RESET1, 0); `CHK(lat >= 60, 1'b1)
    `CHK(lat < 80, 1'b1)
    `CHK(cmd_busy, 1'b0)
    erase_timeout = 0;
    $display("abort test done");
  endtask
  task automatic t_susp();
    suspended = 1;
    run(flash_host_pkg::OP_IDENT, 0); `CHK(rf, 1'b0)
    run(flash_host_pkg::OP_RESET1, 0); `CHK(mode, flash_host_pkg::MODE_SUSPEND)
    run(flash_host_pkg::OP_RESET1, 0); `CHK(mode, flash_host_pkg::MODE_SUSPEND)
    $display("suspend test done");
  endtask
  initial begin #400000; fails++; summarize(); end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    `CHK(mode, flash_host_pkg::MODE_ARRAY)
    `CHK(we_n, 1'b1)
    t_ident(); t_query(); t_x8(); t_busy(); t_abort(); t_susp();
    summarize();
  end
endmodule // flash_cmd_host_tb
`default_nettype wire
